// *** shared/asp_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the serial port host
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// Byte offsets on the Avalon-MM slave
`define ASP_OFS_CTRL 5'h00
`define ASP_OFS_CMD 5'h04
`define ASP_OFS_TXDATA 5'h08
`define ASP_OFS_RXDATA 5'h0C
`define ASP_OFS_STATUS 5'h10

// Control register fields
`define ASP_CTRL_CRC_EN 0
`define ASP_CTRL_CRC_XOR 1
`define ASP_CTRL_CONT 2
`define ASP_CTRL_THREE_WIRE 3
`define ASP_CTRL_WAIT_RDY 4
`define ASP_CTRL_RESET 5'h00

// Command register fields
`define ASP_CMD_BYTE_MSB 7
`define ASP_CMD_NBYTES_LSB 8
`define ASP_CMD_NBYTES_MSB 10
`define ASP_CMD_SER_RST 16
`define ASP_CMD_EXIT 17
`define ASP_CMD_READ_BIT 6
`define ASP_MAX_DATA_BYTES 3'h4

// Status register fields
`define ASP_STAT_BUSY 0
`define ASP_STAT_DATA_READY 1
`define ASP_STAT_CHK_ERR 2
`define ASP_STAT_CONT 3
`define ASP_STAT_RX_SUM_LSB 8
`define ASP_STAT_CALC_SUM_LSB 16

// Link constants
`define ASP_DUMMY_READ_CMD 8'h44
`define ASP_CRC_POLY 8'h07
`define ASP_RESET_ONES 7'h40
`define ASP_SCLK_HALF 4
`define ASP_GAP_CYCLES 4'h8
`define ASP_RDY_SETTLE 3'h3

// Timing
`define ASP_CLK_PERIOD_NS 100
`define ASP_RESET_WAIT_US 500

`endif

// *** shared/asp_pkg.sv ***
// Types shared by the serial port host modules
`default_nettype none
package asp_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_prime,
        st_wait_rdy,
        st_shift,
        st_gap,
        st_rst_wait
    } asp_state_t;

    typedef logic [7:0] asp_byte_t;

endpackage
`default_nettype wire

// *** design/asp_sclk_gen.sv ***
// Serial clock divider with rise and fall strobes
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

module asp_sclk_gen #(
    parameter int HALF = `ASP_SCLK_HALF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic run,
    // Serial clock and strobes
    output logic sclk,
    output logic rise,
    output logic fall
);
    import asp_pkg::*;

    logic [7:0] cnt;
    wire logic terminal = run && (cnt == 8'(HALF - 1));

    // Strobes mark the cycle in which sclk changes at the next edge
    assign rise = terminal && !sclk;
    assign fall = terminal && sclk;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt <= 8'h00;
            sclk <= 1'b1;
        end else if (!run) begin
            // Idle high so the first edge seen by the device is a fall
            cnt <= 8'h00;
            sclk <= 1'b1;
        end else if (terminal) begin
            cnt <= 8'h00;
            sclk <= !sclk;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

endmodule
`default_nettype wire

// *** design/asp_checksum.sv ***
// Bit-serial checksum: polynomial CRC or byte-wise XOR
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

module asp_checksum (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Message bits, most significant first
    input wire logic clear,
    input wire logic feed,
    input wire logic bit_in,
    input wire logic xor_mode,
    // Result
    output asp_pkg::asp_byte_t sum
);
    import asp_pkg::*;

    logic [2:0] idx;
    asp_byte_t next_sum;
    wire asp_byte_t crc_step = {sum[6:0], 1'b0} ^ ((sum[7] ^ bit_in) ? `ASP_CRC_POLY : 8'h00);
    wire asp_byte_t xor_step = sum ^ ((8'h80 >> idx) & {8{bit_in}});

    // Zero start, no final inversion: same as long division of the extended message
    assign next_sum = xor_mode ? xor_step : crc_step;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sum <= 8'h00;
            idx <= 3'h0;
        end else if (clear) begin
            sum <= 8'h00;
            idx <= 3'h0;
        end else if (feed) begin
            sum <= next_sum;
            idx <= idx + 3'h1;
        end
    end

endmodule
`default_nettype wire

// *** design/asp_host.sv ***
// Host controller for the converter serial port, steered over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

module asp_host #(
    parameter int SCLK_HALF = `ASP_SCLK_HALF,
    parameter int RESET_WAIT_CYCLES =
        (`ASP_RESET_WAIT_US * 1000 + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Serial link to the converter
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_din,
    input wire logic spi_dout_rdy
);
    import asp_pkg::*;

    function automatic logic [6:0] bytes_to_bits(input logic [2:0] n);
        return {1'b0, n, 3'b000};
    endfunction

    function automatic logic [31:0] align_left(input logic [31:0] d, input logic [2:0] n);
        logic [5:0] sh;
        sh = {(`ASP_MAX_DATA_BYTES - n), 3'b000};
        return d << sh;
    endfunction

    // Software-visible state
    logic [4:0] ctrl;
    logic [31:0] txdata;
    logic [31:0] rxdata;
    logic chk_err;
    asp_byte_t rx_sum;
    logic rd_ack;

    // Latched transfer description
    asp_byte_t lat_cmd;
    logic [2:0] lat_n;
    logic lat_rst;
    logic lat_exit;
    logic lat_has_cmd;
    logic lat_read;
    logic lat_crc;
    logic lat_cont;

    // Sequencer
    asp_state_t state;
    logic [39:0] tx;
    logic [39:0] rx;
    logic [6:0] bit_cnt;
    logic [2:0] prime_cnt;
    logic [3:0] gap_cnt;
    logic [15:0] wait_cnt;
    logic rdy_meta;
    logic rdy_sync;
    logic sclk_rise;
    logic sclk_fall;
    asp_byte_t calc_sum;

    // Bus decode
    wire logic sel_ctrl = avs_address == `ASP_OFS_CTRL;
    wire logic sel_cmd = avs_address == `ASP_OFS_CMD;
    wire logic sel_txdata = avs_address == `ASP_OFS_TXDATA;
    wire logic sel_rxdata = avs_address == `ASP_OFS_RXDATA;
    wire logic sel_status = avs_address == `ASP_OFS_STATUS;
    wire logic busy = state != st_idle;
    wire logic rd_take = avs_read && !rd_ack;
    wire logic cmd_wr = avs_write && sel_cmd && !busy;

    // A command written while busy is held off, not dropped
    assign avs_waitrequest = rd_take || (avs_write && sel_cmd && busy);

    // Decoding of a new command word
    wire logic [2:0] w_n_raw = avs_writedata[`ASP_CMD_NBYTES_MSB:`ASP_CMD_NBYTES_LSB];
    wire logic [2:0] w_n = (w_n_raw > `ASP_MAX_DATA_BYTES) ? `ASP_MAX_DATA_BYTES : w_n_raw;
    wire logic w_rst = avs_writedata[`ASP_CMD_SER_RST];
    wire logic w_exit = avs_writedata[`ASP_CMD_EXIT] && ctrl[`ASP_CTRL_CONT];
    wire logic w_cont = ctrl[`ASP_CTRL_CONT] && !w_exit && !w_rst;
    // The dummy read, like a serial reset, leaves continuous readback
    wire asp_byte_t w_cmd = w_exit ? `ASP_DUMMY_READ_CMD : avs_writedata[7:0];
    wire logic w_read = w_cont || w_exit || w_cmd[`ASP_CMD_READ_BIT];
    wire logic w_crc = ctrl[`ASP_CTRL_CRC_EN];
    wire logic w_need_rdy = !w_rst && (w_cont || w_exit
        || (ctrl[`ASP_CTRL_WAIT_RDY] && w_cmd == `ASP_DUMMY_READ_CMD));
    // Data right-aligned in the register, sent from its top byte down
    wire logic [39:0] w_tx = w_rst ? {40{1'b1}} :
        w_cont ? 40'h00_0000_0000 :
        {w_cmd, (w_read ? 32'h0000_0000 : align_left(txdata, w_n))};

    // Transfer lengths
    wire logic [6:0] cmd_bits = lat_has_cmd ? 7'h08 : 7'h00;
    wire logic [6:0] msg_bits = bytes_to_bits(lat_n + {2'b00, lat_has_cmd});
    wire logic [6:0] total_bits = lat_rst ? `ASP_RESET_ONES :
        msg_bits + (lat_crc ? 7'h08 : 7'h00);
    wire logic last_bit = (bit_cnt + 7'h01) == total_bits;
    wire logic load_crc = lat_crc && !lat_read && !lat_rst && bit_cnt == msg_bits;

    // Checksum feed: command bits as driven, data bits as driven or received
    wire logic in_msg = bit_cnt < msg_bits;
    wire logic msg_bit = (bit_cnt < cmd_bits || !lat_read) ? tx[39] : rdy_sync;
    wire asp_byte_t prime_byte = `ASP_DUMMY_READ_CMD;
    wire logic prime_bit = prime_byte[3'h7 - prime_cnt];
    wire logic chk_feed = (state == st_prime)
        || (state == st_shift && sclk_rise && in_msg && !lat_rst);
    wire logic chk_bit = (state == st_prime) ? prime_bit : msg_bit;
    // Writes are always CRC; the XOR choice applies to reads only
    wire logic chk_xor = lat_read && ctrl[`ASP_CTRL_CRC_XOR];

    // End of transfer results
    wire logic gap_first = state == st_gap && gap_cnt == 4'h0;
    wire logic got_read = gap_first && lat_read && !lat_rst;
    wire logic chk_set = got_read && lat_crc && rx[7:0] != calc_sum;
    wire logic clr_cont = gap_first && (lat_exit || lat_rst);

    // Status and read mux
    wire logic [31:0] status_word = {8'h00, calc_sum, rx_sum, 4'h0,
        lat_cont, chk_err, !rdy_sync, busy};
    wire logic [31:0] cmd_word = {14'h0000, lat_exit, lat_rst, 5'h00, lat_n, lat_cmd};
    wire logic [31:0] rd_mux = sel_ctrl ? {27'h000_0000, ctrl} :
        sel_cmd ? cmd_word :
        sel_txdata ? txdata :
        sel_rxdata ? rxdata :
        sel_status ? status_word : 32'h0000_0000;

    // Pin input: two flip-flops before any logic
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdy_meta <= 1'b1;
            rdy_sync <= 1'b1;
        end else begin
            rdy_meta <= spi_dout_rdy;
            rdy_sync <= rdy_meta;
        end
    end

    // Register slave: reads answer one edge after they are taken
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            rd_ack <= rd_take;
            if (rd_take) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl <= `ASP_CTRL_RESET;
            txdata <= 32'h0000_0000;
        end else begin
            if (avs_write && sel_ctrl) begin
                ctrl <= avs_writedata[4:0];
            end
            if (avs_write && sel_txdata) begin
                txdata <= avs_writedata;
            end
            // Device leaves continuous readback, so the host view follows
            if (clr_cont) begin
                ctrl[`ASP_CTRL_CONT] <= 1'b0;
            end
        end
    end

    // Sticky mismatch: a set in the clearing cycle wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chk_err <= 1'b0;
        end else if (chk_set) begin
            chk_err <= 1'b1;
        end else if (rd_take && sel_status) begin
            chk_err <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxdata <= 32'h0000_0000;
            rx_sum <= 8'h00;
        end else if (got_read) begin
            rxdata <= lat_crc ? rx[39:8] : rx[31:0];
            rx_sum <= rx[7:0];
        end
    end

    // Transfer description, captured when a command is accepted
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lat_cmd <= 8'h00;
            lat_n <= 3'h0;
            lat_rst <= 1'b0;
            lat_exit <= 1'b0;
            lat_has_cmd <= 1'b0;
            lat_read <= 1'b0;
            lat_crc <= 1'b0;
            lat_cont <= 1'b0;
        end else if (cmd_wr) begin
            lat_cmd <= w_cmd;
            lat_n <= w_n;
            lat_rst <= w_rst;
            lat_exit <= w_exit;
            lat_has_cmd <= !w_cont && !w_rst;
            lat_read <= w_read;
            lat_crc <= w_crc && !w_rst;
            lat_cont <= w_cont;
        end
    end

    // Sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= st_idle;
            prime_cnt <= 3'h0;
            gap_cnt <= 4'h0;
            wait_cnt <= 16'h0000;
        end else begin
            case (state)
                st_idle: begin
                    prime_cnt <= 3'h0;
                    if (cmd_wr) begin
                        if (w_cont && w_crc) begin
                            state <= st_prime;
                        end else if (w_need_rdy) begin
                            state <= st_wait_rdy;
                        end else begin
                            state <= st_shift;
                        end
                    end
                end
                st_prime: begin
                    prime_cnt <= prime_cnt + 3'h1;
                    if (prime_cnt == 3'h7) begin
                        state <= st_wait_rdy;
                    end
                end
                st_wait_rdy: begin
                    // Ready is only visible while selected: let the synchroniser refill first
                    if (prime_cnt != `ASP_RDY_SETTLE) begin
                        prime_cnt <= prime_cnt + 3'h1;
                    end else if (!rdy_sync) begin
                        state <= st_shift;
                    end
                end
                st_shift: begin
                    if (sclk_rise && last_bit) begin
                        state <= st_gap;
                    end
                end
                st_gap: begin
                    gap_cnt <= gap_cnt + 4'h1;
                    if (gap_cnt == `ASP_GAP_CYCLES - 4'h1) begin
                        gap_cnt <= 4'h0;
                        state <= lat_rst ? st_rst_wait : st_idle;
                    end
                end
                st_rst_wait: begin
                    wait_cnt <= wait_cnt + 16'h0001;
                    if (wait_cnt == 16'(RESET_WAIT_CYCLES - 1)) begin
                        wait_cnt <= 16'h0000;
                        state <= st_idle;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // Shift registers: drive on falling sclk, sample on rising sclk
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx <= 40'h00_0000_0000;
            rx <= 40'h00_0000_0000;
            bit_cnt <= 7'h00;
        end else if (cmd_wr) begin
            tx <= w_tx;
            rx <= 40'h00_0000_0000;
            bit_cnt <= 7'h00;
        end else if (state == st_shift) begin
            if (sclk_rise) begin
                bit_cnt <= bit_cnt + 7'h01;
                if (bit_cnt >= cmd_bits && !lat_rst) begin
                    rx <= {rx[38:0], rdy_sync};
                end
            end
            if (sclk_fall && bit_cnt != 7'h00) begin
                if (load_crc) begin
                    tx <= {calc_sum, 32'h0000_0000};
                end else begin
                    // Ones keep flowing during a serial reset, zeros otherwise
                    tx <= {tx[38:0], lat_rst};
                end
            end
        end else if (state == st_idle) begin
            // Data line rests low between transfers
            tx <= 40'h00_0000_0000;
        end
    end

    // Select follows the sequencer unless wired low for 3-wire use
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            spi_cs_n <= 1'b1;
        end else begin
            spi_cs_n <= !(ctrl[`ASP_CTRL_THREE_WIRE]
                || state == st_wait_rdy || state == st_shift);
        end
    end

    assign spi_din = tx[39];

    asp_sclk_gen #(
        .HALF(SCLK_HALF)
    ) u_sclk (
        .clk(clk),
        .reset(reset),
        .run(state == st_shift),
        .sclk(spi_sclk),
        .rise(sclk_rise),
        .fall(sclk_fall)
    );

    asp_checksum u_chk (
        .clk(clk),
        .reset(reset),
        .clear(cmd_wr),
        .feed(chk_feed),
        .bit_in(chk_bit),
        .xor_mode(chk_xor),
        .sum(calc_sum)
    );

endmodule
`default_nettype wire

// *** tb/asp_host_assertions.sv ***
// Port-level checks for the serial port host
`timescale 1ns/1ps
`default_nettype none

module asp_host_checker #(
    parameter int SCLK_HALF = 4,
    parameter int RESET_WAIT_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Serial link
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_din,
    input wire logic spi_dout_rdy
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    wire logic mapped = avs_address inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};

    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    // Counts assume the bench's SCLK_HALF of 4
    sequence s_low_half;
        !spi_sclk [*4] ##1 spi_sclk;
    endsequence

    a_sclk_idle: assert property (spi_cs_n |-> spi_sclk)
        else $error("serial clock not high while deselected");
    a_low_half: assert property ($fell(spi_sclk) |-> s_low_half)
        else $error("serial clock low phase wrong");
    a_high_half: assert property ($rose(spi_sclk) |-> spi_sclk [*4])
        else $error("serial clock high phase too short");
    a_fall_selected: assert property ($fell(spi_sclk) |-> !spi_cs_n)
        else $error("serial clock toggled while deselected");
    a_cs_lead: assert property ($fell(spi_cs_n) |-> spi_sclk [*2])
        else $error("select fell too close to a clock edge");
    a_din_settled: assert property ($rose(spi_sclk) |-> $stable(spi_din))
        else $error("data line moved at sampling edge");
    a_read_wait: assert property ($rose(avs_read) |-> s_one_wait)
        else $error("read did not take one wait state");
    a_write_nowait: assert property (avs_write && avs_address != 5'h04 |-> !avs_waitrequest)
        else $error("plain register write stalled");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && !mapped |->
        avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind asp_host asp_host_checker #(
    .SCLK_HALF(SCLK_HALF),
    .RESET_WAIT_CYCLES(RESET_WAIT_CYCLES)
) u_checker (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_din(spi_din), .spi_dout_rdy(spi_dout_rdy)
);
`default_nettype wire

// *** tb/asp_dev_model.sv ***
// Behavioural converter serial port facing the host
`timescale 1ns/1ps
`default_nettype none

module asp_dev_model #(
    parameter logic [15:0] REG_VAL = 16'h4321,
    parameter logic [7:0] STATUS_RD_CMD = 8'h40
) (
    // Serial link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout_rdy,
    // Bench side
    input wire logic conv,
    input wire logic [23:0] conv_value,
    input wire logic crc_on,
    input wire logic xor_on,
    input wire logic cont,
    output logic sum_bad = 1'b0,
    output logic rst_seen = 1'b0,
    output logic [31:0] rx_word
);
    logic [39:0] sh = '0;
    logic [31:0] obuf = '0;
    logic [23:0] dreg = '0;
    logic [7:0] cmd = '0;
    logic rdy_n = 1'b1;
    logic sending = 1'b0;
    logic dbit = 1'b0;
    logic last = 1'b1;
    logic dat_rd = 1'b0;
    int nbit = 0;
    int ones = 0;
    int end_n = 0;
    wire logic drv = sending ? dbit : rdy_n;

    // Released line floats: show the opposite of its last level
    assign dout_rdy = cs_n ? ~last : drv;
    always @(drv or cs_n) if (!cs_n) last = drv;

    function automatic logic [7:0] chk(input logic [39:0] m, input int nb, input logic x);
        logic [7:0] c;
        c = 8'h00;
        for (int i = nb - 1; i >= 0; i--) begin
            if (x)
                c[i % 8] = c[i % 8] ^ m[i];
            else
                c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    task automatic start(input logic dr);
        dat_rd = dr;
        if (dr)
            obuf = {dreg, chk({8'h44, dreg}, 32, xor_on)};
        else
            obuf = {REG_VAL, chk({cmd, REG_VAL}, 24, xor_on), 8'h00};
        end_n = nbit + (dr ? 24 : 16) + (crc_on ? 8 : 0);
        sending = 1'b1;
    endtask

    always @(posedge conv) begin
        rdy_n = 1'b1;
        #200;
        dreg = conv_value;
        rdy_n = 1'b0;
    end

    always @(posedge sclk) begin
        if (!cs_n) begin
            sh = {sh[38:0], din};
            nbit++;
            ones = din ? ones + 1 : 0;
            if (nbit == 8)
                cmd = sh[7:0];
            // Reading the status register drops the error flag
            if (nbit == 8 && sh[7:0] == STATUS_RD_CMD)
                sum_bad = 1'b0;
            if (ones == 64) begin
                nbit = 0;
                ones = 0;
                dreg = '0;
                rdy_n = 1'b1;
                sending = 1'b0;
                rst_seen = 1'b1;
            end else if (nbit == 8 && !cont && cmd[6]) begin
                start(cmd == 8'h44);
            end else if (sending && nbit == end_n) begin
                sending = 1'b0;
                nbit = 0;
                if (dat_rd)
                    rdy_n = 1'b1;
            end
        end
    end

    always @(negedge sclk) begin
        if (!cs_n && cont && !sending && nbit == 0 && !rdy_n)
            start(1'b1);
        if (!cs_n && sending) begin
            dbit = obuf[31];
            obuf = obuf << 1;
        end
    end

    always @(posedge cs_n) begin
        if (crc_on && nbit > 8 && !cmd[6])
            sum_bad = chk(sh >> 8, nbit - 8, 1'b0) != sh[7:0];
        rx_word = sh[31:0];
        nbit = 0;
        sending = 1'b0;
    end
endmodule
`default_nettype wire

// *** tb/adc_serial_port_with_checksum_test.sv ***
// Self-checking bench for the serial port host
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

module adc_serial_port_with_checksum_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rx_word, q;
    logic avs_waitrequest, spi_cs_n, spi_sclk, spi_din, spi_dout_rdy, sum_bad, rst_seen;
    logic conv = 1'b0;
    logic crc_on = 1'b0;
    logic xor_on = 1'b0;
    logic cont = 1'b0;
    logic [23:0] conv_value = 24'h0;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;

    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    asp_host #(.SCLK_HALF(4), .RESET_WAIT_CYCLES(20)) uut (
        .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_din(spi_din), .spi_dout_rdy(spi_dout_rdy)
    );
    asp_dev_model dev (
        .cs_n(spi_cs_n), .sclk(spi_sclk), .din(spi_din), .dout_rdy(spi_dout_rdy),
        .conv(conv), .conv_value(conv_value), .crc_on(crc_on), .xor_on(xor_on),
        .cont(cont), .sum_bad(sum_bad), .rst_seen(rst_seen), .rx_word(rx_word)
    );

    task automatic end_sim();
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds the request until waitrequest is seen low; read data lands in q
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, `ASP_OFS_STATUS, 32'h0);
            n++;
        end while (q[`ASP_STAT_BUSY] !== 1'b0 && n < 1000);
        if (n >= 1000)
            n_errors++;
    endtask

    task automatic t_regs();
        bus(1'b0, `ASP_OFS_CTRL, 32'h0);
        cmp("ctrl reset", 32'h0, q);
        bus(1'b0, 5'h14, 32'h0);
        cmp("unmapped", 32'h0, q);
    endtask

    // Read checksum set to XOR: writes must still carry the polynomial
    task automatic t_write();
        crc_on <= 1'b1;
        xor_on <= 1'b1;
        bus(1'b1, `ASP_OFS_CTRL, 32'h3);
        bus(1'b1, `ASP_OFS_TXDATA, 32'h4321);
        bus(1'b1, `ASP_OFS_CMD, 32'h225);
        wait_idle();
        cmp("write frame", 32'h2543_2100, rx_word & 32'hFFFF_FF00);
        cmp("write sum", 32'h0, 32'(sum_bad));
    endtask

    task automatic t_read_sums();
        logic [7:0] s [2] = '{8'h86, 8'h07};
        for (int i = 0; i < 2; i++) begin
            xor_on <= i[0];
            bus(1'b1, `ASP_OFS_CTRL, {30'h0, i[0], 1'b1});
            bus(1'b1, `ASP_OFS_CMD, 32'h265);
            wait_idle();
            cmp("read sums", {8'h0, s[i], s[i], 8'h0}, q & 32'h00FF_FF04);
            bus(1'b0, `ASP_OFS_RXDATA, 32'h0);
            cmp("read data", 32'h4321, q);
        end
    endtask

    // Select held low, so the shared line shows ready throughout
    task automatic t_ready();
        crc_on <= 1'b0;
        xor_on <= 1'b0;
        bus(1'b1, `ASP_OFS_CTRL, 32'h18);
        bus(1'b1, `ASP_OFS_CMD, 32'h344);
        bus(1'b0, `ASP_OFS_STATUS, 32'h0);
        cmp("waiting", 32'h1, q & 32'h3);
        conv_value <= 24'hA5C3E1;
        conv <= 1'b1;
        wait_idle();
        cmp("ready after read", 32'h0, q & 32'h3);
        bus(1'b0, `ASP_OFS_RXDATA, 32'h0);
        cmp("result", 32'hA5C3E1, q);
        bus(1'b1, `ASP_OFS_CTRL, 32'h08);
        bus(1'b1, `ASP_OFS_CMD, 32'h344);
        wait_idle();
        bus(1'b0, `ASP_OFS_RXDATA, 32'h0);
        cmp("re-read", 32'hA5C3E1, q);
    endtask

    // Zero data still checks clean only if the implied command is counted
    task automatic t_cont();
        conv <= 1'b0;
        crc_on <= 1'b1;
        cont <= 1'b1;
        bus(1'b1, `ASP_OFS_CTRL, 32'h05);
        bus(1'b1, `ASP_OFS_CMD, 32'h300);
        conv_value <= 24'h0;
        conv <= 1'b1;
        wait_idle();
        cmp("cont status", 32'h8, q & 32'hD);
        bus(1'b0, `ASP_OFS_RXDATA, 32'h0);
        cmp("cont data", 32'h0, q);
    endtask

    task automatic t_reset();
        int t0;
        t0 = cyc;
        bus(1'b1, `ASP_OFS_CMD, 32'h1_0000);
        wait_idle();
        cmp("reset seen", 32'h1, 32'(rst_seen));
        cmp("reset span", 32'h1, 32'(cyc - t0 >= 64 * 8 + 20));
        bus(1'b0, `ASP_OFS_CTRL, 32'h0);
        cmp("ctrl after reset", 32'h1, q);
        cont <= 1'b0;
    endtask

    initial begin
        #3_000_000;
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_write();
        t_read_sums();
        t_ready();
        t_cont();
        t_reset();
        end_sim();
    end
endmodule
`default_nettype wire
